// [design/ebt_pkg.sv]
package ebt_pkg;

  // Bus geometry and register map
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam logic [ADR_W-1:0] OFS_PRESCALE = 8'h00;
  localparam logic [ADR_W-1:0] CH_BASE = 8'h10;
  localparam logic [ADR_W-1:0] CH_STRIDE = 8'h10;
  localparam logic [ADR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] OFS_PERIOD = 8'h04;
  localparam logic [ADR_W-1:0] OFS_DUTY = 8'h08;
  localparam logic [ADR_W-1:0] OFS_COUNT = 8'h0C;

  // Reset values and counter constants
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hFF;
  localparam logic [7:0] RST_DUTY = 8'h80;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CNT_TOP = 8'hFF;
  localparam logic [7:0] CNT_ONE = 8'h01;

  // Field positions in the channel control register, and of the flip-flop status in the count read word
  localparam int FF_INIT_BIT = 7;
  localparam int RUN_BIT = 3;
  localparam int STATUS_FF_BIT = 8;

  // Prescaler of the high-frequency clock
  localparam int PRE_W = 13;
  localparam logic [3:0] EXP_SEL0 = 4'h0B;
  localparam logic [3:0] EXP_SEL1 = 4'h07;
  localparam logic [3:0] EXP_SEL2 = 4'h05;
  localparam logic [3:0] EXP_SEL3 = 4'h03;
  localparam logic [3:0] EXP_DOUBLE = 4'h01;

  typedef enum logic [2:0] {
    EBT_MODE_TIMER = 3'b000,
    EBT_MODE_PDO = 3'b001,
    EBT_MODE_PWM = 3'b010,
    EBT_MODE_RSVD = 3'b011
  } ebt_mode_t;

  typedef enum logic [2:0] {
    EBT_CS_SEL0 = 3'b000,
    EBT_CS_SEL1 = 3'b001,
    EBT_CS_SEL2 = 3'b010,
    EBT_CS_SEL3 = 3'b011,
    EBT_CS_PIN = 3'b111
  } ebt_clksel_t;

  // Layout of channel_control_reg
  typedef struct packed {
    logic flipflop_init_bit;
    logic [2:0] source_clock_field;
    logic run_control_bit;
    logic [2:0] op_mode_field;
  } ebt_ctrl_t;

  // One classic Wishbone request
  typedef struct packed {
    logic [ADR_W-1:0] adr;
    logic [DAT_W-1:0] dat;
    logic [3:0] sel;
    logic we;
    logic cyc;
    logic stb;
  } ebt_wb_req_t;

endpackage

// [design/ebt_edge_sync.sv]
`timescale 1ns/100ps
module ebt_edge_sync
  import ebt_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic fall_o
);

  logic s1;
  logic s2;
  logic s3;
  logic level;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Filtered falling edge
  // A change is taken only when stages two and three agree, so one edge counts once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level <= 1'b1;
      fall_o <= 1'b0;
    end else begin
      fall_o <= 1'b0;
      if (s2 == s3 && s3 != level) begin
        level <= s3;
        fall_o <= level & ~s3;
      end
    end
  end

endmodule

// [design/ebt_timer.sv]
`timescale 1ns/100ps
// Overview of operation
// - Timer mode counts prescaled clock; match raises interrupt, clears counter, continues.
// - Period register is unbuffered; software leaves it alone while running.
// - Event mode counts event pin falling edges; match interrupts and clears.
// - Event high and low phases last two machine cycles at least.
// - Divider mode toggles flip-flop on match, clears counter, raises interrupt.
// - Divider pin drives the inverse of the channel flip-flop.
// - Init bit presets flip-flop to either level; reset clears it.
// - Stopping holds output level; flip-flop rewritten only after the stop.
// - Run is control bit 3, init is bit 7; clearing 7 stopped drives pin high.
// - PWM toggles on duty match and again on overflow, which clears and interrupts.
// - PWM pin drives the inverse of the channel flip-flop.
// - Duty register double-buffered; loaded at interrupt when running, at once stopped.
// - Duty reads return the effective value until the next load.
// - Source clock is fc over 2^11, 2^7, 2^5, 2^3, doubled by divide-select.
// - Setting run starts counting; clearing run stops and clears counter.
// - Mode 000 timer or event, 001 divider, 010 PWM, 011 reserved.
module ebt_timer
  import ebt_pkg::*;
#(
  parameter int NCH = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NCH-1:0] event_in_pin_i,
  output logic [NCH-1:0] divider_out_pin_o,
  output logic [NCH-1:0] pwm_out_pin_o,
  output logic [NCH-1:0] channel_match_irq_o
);

  ebt_wb_req_t req;
  logic bus_req;
  logic wr_en;
  logic [PRE_W-1:0] pre_cnt;
  logic [PRE_W-1:0] tick_e;
  logic prescaler_div_select;
  logic [DAT_W-1:0] next_rdata;

  ebt_ctrl_t channel_control_reg [NCH];
  logic [7:0] period_match_reg [NCH];
  logic [7:0] duty_buf [NCH];
  logic [7:0] pwm_duty_reg [NCH];
  logic [7:0] cnt [NCH];
  logic [NCH-1:0] tff;
  logic [NCH-1:0] ev_fall;

  function automatic logic [ADR_W-1:0] ch_addr(input int ch, input logic [ADR_W-1:0] ofs);
    ch_addr = ADR_W'(CH_BASE + ADR_W'(ch) * CH_STRIDE + ofs);
  endfunction

  assign req = '{adr: wb_adr_i, dat: wb_dat_i, sel: wb_sel_i, we: wb_we_i,
                 cyc: wb_cyc_i, stb: wb_stb_i};
  assign bus_req = req.cyc & req.stb;
  // Writes land on the edge where ack is high, matching the master's sample point
  assign wr_en = bus_req & wb_ack_o & req.we & req.sel[0];

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prescaler_div_select <= 1'b0;
    end else if (wr_en && req.adr == OFS_PRESCALE) begin
      prescaler_div_select <= req.dat[0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_cnt <= '0;
    end else begin
      pre_cnt <= PRE_W'(pre_cnt + 1'b1);
    end
  end

  for (genvar e = 0; e < PRE_W; e++) begin : g_tick
    localparam logic [PRE_W-1:0] MASK = PRE_W'((64'h1 << e) - 64'h1);
    assign tick_e[e] = (pre_cnt & MASK) == MASK;
  end

  // Read mux: unmapped addresses read zero
  always_comb begin
    next_rdata = '0;
    if (req.adr == OFS_PRESCALE) begin
      next_rdata[0] = prescaler_div_select;
    end
    for (int c = 0; c < NCH; c++) begin
      if (req.adr == ch_addr(c, OFS_CTRL)) begin
        next_rdata[7:0] = channel_control_reg[c];
      end
      if (req.adr == ch_addr(c, OFS_PERIOD)) begin
        next_rdata[7:0] = period_match_reg[c];
      end
      if (req.adr == ch_addr(c, OFS_DUTY)) begin
        next_rdata[7:0] = pwm_duty_reg[c];
      end
      if (req.adr == ch_addr(c, OFS_COUNT)) begin
        next_rdata[7:0] = cnt[c];
        next_rdata[STATUS_FF_BIT] = tff[c];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (bus_req && !wb_ack_o) begin
      wb_dat_o <= next_rdata;
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    localparam logic [ADR_W-1:0] A_CTRL = ch_addr(g, OFS_CTRL);
    localparam logic [ADR_W-1:0] A_PERIOD = ch_addr(g, OFS_PERIOD);
    localparam logic [ADR_W-1:0] A_DUTY = ch_addr(g, OFS_DUTY);

    ebt_ctrl_t wctrl;
    ebt_mode_t mode;
    logic run;
    logic wr_ctrl;
    logic wr_duty;
    logic src;
    logic [3:0] exp_sel;
    logic [7:0] cnt_inc;
    logic match_hit;
    logic ovf_hit;
    logic duty_hit;
    logic stopping;

    assign wctrl = ebt_ctrl_t'(req.dat[7:0]);
    assign mode = ebt_mode_t'(channel_control_reg[g].op_mode_field);
    assign run = channel_control_reg[g].run_control_bit;
    assign wr_ctrl = wr_en && req.adr == A_CTRL;
    assign wr_duty = wr_en && req.adr == A_DUTY;
    assign cnt_inc = 8'(cnt[g] + CNT_ONE);
    assign stopping = wr_ctrl && run && !wctrl.run_control_bit;

    // Edge filter relies on each event phase spanning several clocks
    ebt_edge_sync u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(event_in_pin_i[g]),
      .fall_o(ev_fall[g])
    );

    always_comb begin
      case (ebt_clksel_t'(channel_control_reg[g].source_clock_field))
        EBT_CS_SEL0: exp_sel = EXP_SEL0;
        EBT_CS_SEL1: exp_sel = EXP_SEL1;
        EBT_CS_SEL2: exp_sel = EXP_SEL2;
        default: exp_sel = EXP_SEL3;
      endcase
      exp_sel = 4'(exp_sel + (prescaler_div_select ? EXP_DOUBLE : 4'h0));
      // Pin source counts filtered falling edges
      if (ebt_clksel_t'(channel_control_reg[g].source_clock_field) == EBT_CS_PIN) begin
        src = ev_fall[g];
      end else begin
        src = tick_e[exp_sel];
      end
    end

    assign match_hit = run && src && (mode == EBT_MODE_TIMER || mode == EBT_MODE_PDO)
                       && cnt_inc == period_match_reg[g];
    assign ovf_hit = run && src && mode == EBT_MODE_PWM && cnt[g] == CNT_TOP;
    assign duty_hit = run && src && mode == EBT_MODE_PWM && cnt_inc == pwm_duty_reg[g];

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        channel_control_reg[g] <= ebt_ctrl_t'(RST_CTRL);
      end else if (wr_ctrl) begin
        channel_control_reg[g] <= wctrl;
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        period_match_reg[g] <= RST_PERIOD;
      end else if (wr_en && req.adr == A_PERIOD) begin
        period_match_reg[g] <= req.dat[7:0];
      end
    end

    // Counter stops and clears when run is low
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cnt[g] <= CNT_ZERO;
      end else if (!run) begin
        cnt[g] <= CNT_ZERO;
      end else if (src) begin
        case (mode)
          // Clear on match and keep counting
          EBT_MODE_TIMER, EBT_MODE_PDO: cnt[g] <= match_hit ? CNT_ZERO : cnt_inc;
          EBT_MODE_PWM: cnt[g] <= cnt_inc;
          default: cnt[g] <= cnt[g];
        endcase
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        tff[g] <= 1'b0;
      end else if (wr_ctrl && !stopping && (!run || wctrl.run_control_bit && !run)) begin
        tff[g] <= wctrl.flipflop_init_bit;
      end else if (stopping) begin
        // Level held through the stopping write
        tff[g] <= tff[g];
      end else if (match_hit && mode == EBT_MODE_PDO) begin
        tff[g] <= ~tff[g];
      end else if (duty_hit || ovf_hit) begin
        // Toggle on duty match and overflow
        tff[g] <= ~tff[g];
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        duty_buf[g] <= RST_DUTY;
      end else if (wr_duty) begin
        duty_buf[g] <= req.dat[7:0];
      end
    end

    // Load at overflow interrupt while running in PWM mode, at once otherwise
    // A write racing the load transfers the old buffer; new value waits a period
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        pwm_duty_reg[g] <= RST_DUTY;
      end else if (wr_duty && !(run && mode == EBT_MODE_PWM)) begin
        pwm_duty_reg[g] <= req.dat[7:0];
      end else if (ovf_hit) begin
        pwm_duty_reg[g] <= duty_buf[g];
      end
    end

    // Interrupt pulse on match or overflow
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        channel_match_irq_o[g] <= 1'b0;
      end else begin
        channel_match_irq_o[g] <= match_hit | ovf_hit;
      end
    end

    assign divider_out_pin_o[g] = ~tff[g];
    assign pwm_out_pin_o[g] = ~tff[g];
  end

endmodule

// [verif/ebt_timer_properties.sv]
`timescale 1ns/100ps
module ebt_timer_properties
  import ebt_pkg::*;
#(
  parameter int NCH = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [DAT_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [NCH-1:0] divider_out_pin_o,
  input wire logic [NCH-1:0] pwm_out_pin_o,
  input wire logic [NCH-1:0] channel_match_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_answer;
    $rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("ack missing");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_unmapped_zero;
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == 8'h40 |=> wb_dat_o == '0;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
  property p_data_hold;
    !(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("read data moved");
  property p_pins_same;
    divider_out_pin_o == pwm_out_pin_o;
  endproperty
  a_pins_same: assert property (p_pins_same) else $error("pins disagree");
  // Reset must not be masked here, it is the cause
  property p_reset_pins;
    disable iff (1'b0) rst_i |=> divider_out_pin_o == '1 && channel_match_irq_o == '0;
  endproperty
  a_reset_pins: assert property (p_reset_pins) else $error("pins after reset");
  property p_irq_gap;
    channel_match_irq_o[0] |=> !channel_match_irq_o[0] [*7];
  endproperty
  a_irq_gap: assert property (p_irq_gap) else $error("interrupt too soon");
endmodule

bind ebt_timer ebt_timer_properties #(.NCH(NCH)) i_ebt_timer_properties (
  .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .divider_out_pin_o(divider_out_pin_o), .pwm_out_pin_o(pwm_out_pin_o),
  .channel_match_irq_o(channel_match_irq_o));

// [verif/ebt_event_src.sv]
`timescale 1ns/100ps
module ebt_event_src #(
  parameter int PH = 4
) (
  input wire logic clk_i,
  input wire logic [7:0] n_i,
  input wire logic go_i,
  output logic pin_o,
  output logic busy_o
);
  int k;
  initial begin
    pin_o = 1'b1;
    busy_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (go_i === 1'b1) begin
        busy_o <= 1'b1;
        k = n_i;
        repeat (k) begin
          pin_o <= 1'b0;
          repeat (PH) @(posedge clk_i);
          pin_o <= 1'b1;
          repeat (PH) @(posedge clk_i);
        end
        busy_o <= 1'b0;
      end
    end
  end
endmodule

// [verif/ebt_timer_tb.sv]
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("ERROR %0t got %0h want %0h", $time, (a), (b)); end end
module ebt_timer_tb;
  import ebt_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic w; logic [31:0] e;} ebt_row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  ebt_wb_req_t req = '0;
  logic [DAT_W-1:0] wb_dat_o;
  logic wb_ack_o, ev_pin, busy;
  logic go = 1'b0;
  logic [7:0] n_ev = 8'h00;
  logic [1:0] div_pin, pwm_pin, irq;
  logic [31:0] rd;
  logic [3:0] exps[4] = '{EXP_SEL0, EXP_SEL1, EXP_SEL2, EXP_SEL3};
  int fail_count = 0, n_checks = 0, cyc_n = 0, irq_n = 0, lo, pe, t, n, base;
  ebt_row_t rows[8] = '{'{8'h10, 8'h00, 1'b0, 8'h00}, '{8'h14, 8'h00, 1'b0, 8'hFF},
    '{8'h18, 8'h00, 1'b0, 8'h80}, '{8'h24, 8'h00, 1'b0, 8'hFF}, '{8'h1C, 8'h00, 1'b0, 8'h00},
    '{8'h40, 8'h00, 1'b0, 8'h00}, '{8'h24, 32'h1234_5605, 1'b1, 8'h00},
    '{8'h24, 8'h00, 1'b0, 8'h05}};
  ebt_timer #(.NCH(2)) i_ebt_timer (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(req.adr),
    .wb_dat_i(req.dat), .wb_sel_i(req.sel), .wb_we_i(req.we), .wb_cyc_i(req.cyc),
    .wb_stb_i(req.stb), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .event_in_pin_i({ev_pin, 1'b1}), .divider_out_pin_o(div_pin), .pwm_out_pin_o(pwm_pin),
    .channel_match_irq_o(irq));
  ebt_event_src i_ebt_event_src (.clk_i(clk_i), .n_i(n_ev), .go_i(go), .pin_o(ev_pin),
    .busy_o(busy));
  initial forever #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) cyc_n <= cyc_n + 1;
  always @(posedge clk_i) if (irq[1] === 1'b1) irq_n <= irq_n + 1;
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w);
    int k;
    k = 0;
    @(posedge clk_i);
    req <= '{a, d, 4'h1, w, 1'b1, 1'b1};
    do begin @(posedge clk_i); k++; end while (wb_ack_o !== 1'b1 && k < 100);
    rd = wb_dat_o;
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
    if (k >= 100) fail_count++;
  endtask
  // Polls the interrupt (k=0) or the divider pin (k=1) of channel 0, bounded
  task automatic wt(input int k, input logic v);
    int m;
    m = 0;
    while ((k ? div_pin[0] : irq[0]) !== v && m < 10000) begin @(posedge clk_i); m++; end
    if (m >= 10000) fail_count++;
  endtask
  task automatic measure(input int k);
    wt(k, 1); wt(k, 0); t = cyc_n; wt(k, 1); lo = cyc_n - t;
    t = cyc_n; wt(k, 0); wt(k, 1); pe = cyc_n - t;
  endtask
  initial begin
    // Tests need about 30000 cycles, dominated by the slowest timer and PWM periods
    repeat (80000) @(posedge clk_i);
    fail_count++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      bus(rows[i].a, rows[i].d, rows[i].w);
      if (!rows[i].w) `CHK(rd, rows[i].e)
    end
    $display("registers done");
    bus(8'h14, 8'h01, 1'b1);
    for (int ds = 0; ds < 2; ds++) for (int s = 0; s < 4; s++) begin
      bus(8'h10, 8'h00, 1'b1);
      bus(8'h00, ds, 1'b1);
      bus(8'h10, 8'h08 | (s << 4), 1'b1);
      measure(0);
      `CHK(pe, 1 << (exps[s] + ds))
    end
    $display("timer done");
    bus(8'h00, 8'h00, 1'b1);
    bus(8'h10, 8'h00, 1'b1);
    bus(8'h14, 8'h02, 1'b1);
    bus(8'h10, 8'h39, 1'b1);
    measure(1);
    // Port latch sits outside the block; pins are watched as driven
    `CHK(lo, 16)
    `CHK(pe, 32)
    bus(8'h10, 8'h31, 1'b1);
    base = div_pin[0];
    repeat (40) @(posedge clk_i);
    `CHK(div_pin[0], base[0])
    bus(8'h1C, 8'h00, 1'b0);
    `CHK(rd[7:0], 8'h00)
    bus(8'h10, 8'h81, 1'b1);
    @(posedge clk_i);
    `CHK(div_pin, 2'h2)
    `CHK(pwm_pin, 2'h2)
    bus(8'h10, 8'h01, 1'b1);
    @(posedge clk_i);
    `CHK(div_pin, 2'h3)
    `CHK(pwm_pin, 2'h3)
    $display("divider done");
    bus(8'h10, 8'h02, 1'b1);
    bus(8'h18, 8'h40, 1'b1);
    bus(8'h18, 8'h00, 1'b0);
    `CHK(rd, 8'h40)
    bus(8'h10, 8'h3A, 1'b1);
    measure(1);
    `CHK(lo, 1536)
    `CHK(pe, 2048)
    wt(0, 1);
    bus(8'h18, 8'hC0, 1'b1);
    bus(8'h18, 8'h00, 1'b0);
    `CHK(rd, 8'h40)
    wt(0, 0);
    wt(0, 1);
    bus(8'h18, 8'h00, 1'b0);
    `CHK(rd, 8'hC0)
    measure(1);
    `CHK(lo, 512)
    bus(8'h10, 8'h32, 1'b1);
    base = pwm_pin[0];
    repeat (40) @(posedge clk_i);
    `CHK(pwm_pin[0], base[0])
    $display("pwm done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    `CHK(div_pin, 2'h3)
    `CHK(irq, 2'h0)
    rst_i <= 1'b0;
    bus(8'h10, 8'h00, 1'b0);
    `CHK(rd, 8'h00)
    $display("reset done");
    bus(8'h24, 8'h03, 1'b1);
    bus(8'h20, 8'h78, 1'b1);
    base = irq_n;
    n_ev <= 8'h07;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (2) @(posedge clk_i);
    n = 0;
    while (busy === 1'b1 && n < 1000) begin @(posedge clk_i); n++; end
    repeat (10) @(posedge clk_i);
    `CHK(irq_n - base, 2)
    bus(8'h2C, 8'h00, 1'b0);
    `CHK(rd[7:0], 8'h01)
    bus(8'h20, 8'h4B, 1'b1);
    base = irq_n;
    repeat (40) @(posedge clk_i);
    bus(8'h2C, 8'h00, 1'b0);
    `CHK(rd[7:0], 8'h01)
    `CHK(irq_n - base, 0)
    $display("event done");
    conclude();
  end
endmodule
